// ### hpsi_defines.vh
// Purpose: Constants for the host port stream interface.
// Assumes: Core clock of 100 MHz.
// Notes: Times are given in their own unit with derived cycle counts.
`ifndef HPSI_DEFINES_VH
`define HPSI_DEFINES_VH
`define HPSI_IDLE_BYTE 8'hFF
`define HPSI_IDLE_RUN 6'd50
`define HPSI_CLK_MHZ 100
`define HPSI_IDLE_TIMEOUT_MS 2000
`define HPSI_IDLE_TIMEOUT_CYC (`HPSI_IDLE_TIMEOUT_MS * 1000 * `HPSI_CLK_MHZ)
`define HPSI_EXT_LIMIT_BYTES 13'd4096
`define HPSI_TXP_TAIL_BYTES 5'd16
`define HPSI_SEL_SPI 1'b0
`define HPSI_BIT_LAST 3'h7
`define HPSI_SYNC_IDLE 5'h1D
`define HPSI_STRAP_SETTLE 3'd4
`endif

// ### hpsi_host.sv
// Purpose: SPI master model of the host.
// Assumes: Mode 0, most significant bit first, 160 ns clock.
// Notes: Clock stands still low between frames.
`timescale 1ns/1ns
module hpsi_host (
	input  wire i_miso,
	output reg  o_cs_n,
	output reg  o_sclk,
	output reg  o_mosi
);
	initial begin
		o_cs_n = 1'b1;
		o_sclk = 1'b0;
		o_mosi = 1'b1;
	end
	task xfer(input [7:0] tx, output [7:0] rx);
		integer i;
		begin
			o_cs_n = 1'b0;
			#160;
			for (i = 7; i >= 0; i = i - 1) begin
				o_mosi = tx[i];
				#80 o_sclk = 1'b1;
				rx[i] = i_miso;
				#80 o_sclk = 1'b0;
			end
			#160 o_cs_n = 1'b1;
			o_mosi = ~o_mosi; // Released line shows no stale level.
			#320;
		end
	endtask
endmodule // hpsi_host

// ### hpsi_monitor.sv
// Purpose: Port level checks for the host port stream interface.
// Assumes: One core clock domain with active low reset.
// Notes: Bound to every instance of the top module.
`timescale 1ns/1ns
module hpsi_monitor #(parameter integer CNT_W = 13) (
	input wire             i_core_clk,
	input wire             i_rst_b,
	input wire             i_tx_valid,
	input wire             i_txp_cfg_wr,
	input wire             i_txp_pin_valid,
	input wire             i_txp_pin_used,
	input wire             o_tx_ready,
	input wire [7:0]       o_rx_data,
	input wire             o_rx_valid,
	input wire             o_parser_active,
	input wire             o_txp_rb_en,
	input wire [CNT_W-1:0] o_txp_rb_thr,
	input wire             o_tx_pending_pin,
	input wire             o_recovery_mode,
	input wire             o_usb_enable,
	input wire             o_strap_spi
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_b);
	a_idle_byte_gate: assert property (o_rx_valid && o_rx_data == 8'hFF |-> $past(o_parser_active))
		else $error("Idle byte delivered while suspended.");
	a_parser_resume: assert property (o_rx_valid && o_rx_data != 8'hFF |=> o_parser_active)
		else $error("Parser not resumed by data byte.");
	a_tx_needs_valid: assert property (o_tx_ready |-> $past(i_tx_valid))
		else $error("Byte consumed with nothing offered.");
	a_tx_byte_gap: assert property (o_tx_ready |=> (!o_tx_ready)[*8])
		else $error("Consume pulses too close.");
	a_rx_byte_gap: assert property (o_rx_valid |=> (!o_rx_valid)[*8])
		else $error("Receive pulses too close.");
	a_txp_reject: assert property (i_txp_cfg_wr && (!i_txp_pin_valid || i_txp_pin_used)
		|=> !o_txp_rb_en && o_txp_rb_thr == 0)
		else $error("Rejected indicator setting not cleared.");
	a_txp_off_low: assert property (!o_txp_rb_en && $past(!o_txp_rb_en) |-> !o_tx_pending_pin)
		else $error("Indicator driven while disabled.");
	a_recovery_usb: assert property (o_recovery_mode |-> !o_usb_enable)
		else $error("USB enabled in recovery mode.");
	a_strap_uart: assert property (!o_strap_spi && $past(!o_strap_spi) |-> !o_rx_valid)
		else $error("SPI byte taken in UART mode.");
endmodule // hpsi_monitor
bind hpsi_top hpsi_monitor #(.CNT_W(CNT_W)) u_mon (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
	.i_tx_valid(i_tx_valid), .i_txp_cfg_wr(i_txp_cfg_wr), .i_txp_pin_valid(i_txp_pin_valid),
	.i_txp_pin_used(i_txp_pin_used), .o_tx_ready(o_tx_ready), .o_rx_data(o_rx_data),
	.o_rx_valid(o_rx_valid), .o_parser_active(o_parser_active), .o_txp_rb_en(o_txp_rb_en),
	.o_txp_rb_thr(o_txp_rb_thr), .o_tx_pending_pin(o_tx_pending_pin),
	.o_recovery_mode(o_recovery_mode), .o_usb_enable(o_usb_enable), .o_strap_spi(o_strap_spi));

// ### hpsi_top.v
// Purpose: Serial host port front end with SPI slave stream, pin routing and tx pending pin.
// Assumes: SPI mode 0, MSB first, active low chip select; pins sampled by core clock.
// Notes: Message bytes enter by a valid/ready byte port and leave by a valid-only byte port.
// Functional notes
// - MISO carries stream bytes, 0xFF when none.
// - Parser suspends after fifty consecutive 0xFF bytes.
// - First non-0xFF byte resumes parser, is processed.
// - Empty transmit queue gives all-ones MISO.
// - Every byte in pairs with one out.
// - Writes are only message stream bytes.
// - Strap routes shared pins: SPI or UART/I2C.
// - Pending pin active at threshold, polarity configurable.
// - Up to sixteen bytes may remain after deassert.
// - Pending indication disabled after reset until configured.
// - Invalid or used pin ignores only indicator.
// - Rejected indicator reads back disabled, all zero.
// - No transfer for two seconds idles port.
// - Extended timeout defers idling until 4 kB backlog.
// - Low recovery boot pin at power-up enters recovery.
// - Recovery mode: only UART, I2C, SPI usable.
// - SPI port is slave only.
`timescale 1ns/1ns
`include "hpsi_defines.vh"
module hpsi_top #(
	parameter integer IDLE_TIMEOUT_CYC = `HPSI_IDLE_TIMEOUT_CYC,
	parameter integer CNT_W            = 13,
	parameter integer PIN_W            = 4
) (
	input  wire             i_core_clk,
	input  wire             i_rst_b,
	input  wire             i_ce,
	input  wire             i_port_sel_pin,
	input  wire             i_recovery_boot_pin_b,
	input  wire             i_pin20,
	input  wire             i_pin21,
	input  wire             i_pin18,
	input  wire             i_pin19,
	output reg              o_pin20,
	output reg              o_pin20_oe,
	output reg              o_pin18,
	output reg              o_pin18_oe,
	input  wire             i_uart_tx,
	output reg              o_uart_rx,
	input  wire             i_i2c_sda,
	input  wire             i_i2c_sda_oe,
	output reg              o_i2c_sda,
	output reg              o_i2c_scl,
	input  wire [7:0]       i_tx_data,
	input  wire             i_tx_valid,
	output reg              o_tx_ready,
	output reg  [7:0]       o_rx_data,
	output reg              o_rx_valid,
	output reg              o_parser_active,
	input  wire [CNT_W-1:0] i_tx_pending,
	input  wire             i_txp_cfg_wr,
	input  wire             i_txp_cfg_en,
	input  wire             i_txp_cfg_pol,
	input  wire [PIN_W-1:0] i_txp_cfg_pin,
	input  wire [CNT_W-1:0] i_txp_cfg_thr,
	input  wire             i_txp_pin_valid,
	input  wire             i_txp_pin_used,
	output reg              o_txp_rb_en,
	output reg              o_txp_rb_pol,
	output reg  [PIN_W-1:0] o_txp_rb_pin,
	output reg  [CNT_W-1:0] o_txp_rb_thr,
	output reg              o_tx_pending_pin,
	input  wire             i_ext_timeout_en,
	input  wire [CNT_W-1:0] i_undelivered,
	output reg              o_port_idle,
	output reg              o_recovery_mode,
	output reg              o_usb_enable,
	output reg              o_positioning_en,
	output reg              o_strap_spi
);

	// Pad inputs in synchroniser order: strap, select, chip select, clock, data.
	localparam integer            SYNC_N    = 5;
	localparam [SYNC_N-1:0]       SYNC_IDLE = `HPSI_SYNC_IDLE;

	// Byte engine state.
	reg  [2:0]        bit_q;
	reg  [7:0]        rx_sh_q;
	reg  [7:0]        tx_sh_q;
	reg  [5:0]        ff_run_q;

	// Idle timeout and boot strap state.
	reg  [31:0]       idle_cnt_q;
	reg               strap_done_q;
	reg  [2:0]        settle_q;
	reg               rec_q;

	// Raw and synchronised pad levels and their next values.
	wire [SYNC_N-1:0] pin_raw;
	wire [SYNC_N-1:0] pin_next;
	wire [SYNC_N-1:0] pin_sync;
	wire              sel_q;
	wire              cs_b_q;
	wire              sclk_q;
	wire              mosi_q;

	function agree;
		input [2:0] s;
		input       prev;
		begin
			agree = (s[1] == s[2]) ? s[2] : prev;
		end
	endfunction

	assign pin_raw = {i_recovery_boot_pin_b, i_port_sel_pin, i_pin18, i_pin19, i_pin21};
	assign sel_q   = pin_sync[3];
	assign cs_b_q  = pin_sync[2];
	assign sclk_q  = pin_sync[1];
	assign mosi_q  = pin_sync[0];

	wire spi_mode = (sel_q == `HPSI_SEL_SPI);
	wire cs_act   = spi_mode & ~cs_b_q;
	wire sclk_n   = pin_next[1];
	wire rise     = cs_act & sclk_n & ~sclk_q;
	wire fall     = cs_act & ~sclk_n & sclk_q;
	wire [7:0] rx_byte = {rx_sh_q[6:0], mosi_q};
	wire byte_end = rise & (bit_q == `HPSI_BIT_LAST);

	// Pin synchronisers: stage 0 feeds stage 1 only; 1 and 2 agree.
	// Reset levels match the idle pads, so no false clock edge follows reset.
	genvar g;
	generate
		for (g = 0; g < SYNC_N; g = g + 1) begin : g_sync
			reg [2:0] stg_q;
			reg       lvl_q;
			assign pin_next[g] = agree(stg_q, lvl_q);
			assign pin_sync[g] = lvl_q;
			always @(posedge i_core_clk or negedge i_rst_b) begin
				if (!i_rst_b) begin
					stg_q <= {3{SYNC_IDLE[g]}};
					lvl_q <= SYNC_IDLE[g];
				end else if (i_ce) begin
					stg_q <= {stg_q[1:0], pin_raw[g]};
					lvl_q <= pin_next[g];
				end
			end
		end
	endgenerate

	// SPI byte engine, shift register and parser gate.
	always @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			bit_q           <= 3'h0;
			rx_sh_q         <= 8'h00;
			tx_sh_q         <= `HPSI_IDLE_BYTE;
			ff_run_q        <= 6'h00;
			o_rx_data       <= 8'h00;
			o_rx_valid      <= 1'b0;
			o_tx_ready      <= 1'b0;
			o_parser_active <= 1'b1;
		end else if (i_ce) begin
			o_rx_valid <= 1'b0;
			o_tx_ready <= 1'b0;
			if (!cs_act) begin
				bit_q <= 3'h0;
				// Load next byte while deselected; empty queue yields 0xFF.
				tx_sh_q <= i_tx_valid ? i_tx_data : `HPSI_IDLE_BYTE;
			end else if (rise) begin
				rx_sh_q <= rx_byte;
				bit_q   <= bit_q + 3'h1;
			end else if (fall && bit_q != 3'h0) begin
				// The fall after the last rise keeps the freshly loaded byte.
				tx_sh_q <= {tx_sh_q[6:0], 1'b1};
			end
			if (byte_end) begin
				// A byte in always pairs with a byte out.
				o_tx_ready <= i_tx_valid;
				tx_sh_q    <= i_tx_valid ? i_tx_data : `HPSI_IDLE_BYTE;
				if (rx_byte == `HPSI_IDLE_BYTE) begin
					if (ff_run_q != `HPSI_IDLE_RUN)
						ff_run_q <= ff_run_q + 6'h1;
					if (ff_run_q + 6'h1 >= `HPSI_IDLE_RUN)
						o_parser_active <= 1'b0;
					else
						o_rx_valid <= o_parser_active;
				end else begin
					ff_run_q        <= 6'h00;
					o_parser_active <= 1'b1;
					o_rx_valid      <= 1'b1;
				end
				o_rx_data <= rx_byte;
			end
		end
	end

	// Shared pin routing by strap; every pad output is registered.
	always @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_pin20    <= 1'b1;
			o_pin20_oe <= 1'b0;
			o_pin18    <= 1'b1;
			o_pin18_oe <= 1'b0;
			o_uart_rx  <= 1'b1;
			o_i2c_sda  <= 1'b1;
			o_i2c_scl  <= 1'b1;
		end else if (i_ce) begin
			o_pin20    <= spi_mode ? tx_sh_q[7] : i_uart_tx;
			o_pin20_oe <= spi_mode ? cs_act : 1'b1;
			o_pin18    <= 1'b0;
			o_pin18_oe <= ~spi_mode & i_i2c_sda_oe & ~i_i2c_sda;
			o_uart_rx  <= spi_mode ? 1'b1 : mosi_q;
			o_i2c_sda  <= spi_mode ? 1'b1 : cs_b_q;
			o_i2c_scl  <= spi_mode ? 1'b1 : sclk_q;
		end
	end

	// Transmit pending configuration and indicator.
	always @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_txp_rb_en      <= 1'b0;
			o_txp_rb_pol     <= 1'b0;
			o_txp_rb_pin     <= {PIN_W{1'b0}};
			o_txp_rb_thr     <= {CNT_W{1'b0}};
			o_tx_pending_pin <= 1'b0;
		end else if (i_ce) begin
			if (i_txp_cfg_wr) begin
				if (i_txp_pin_valid && !i_txp_pin_used) begin
					o_txp_rb_en  <= i_txp_cfg_en;
					o_txp_rb_pol <= i_txp_cfg_pol;
					o_txp_rb_pin <= i_txp_cfg_pin;
					o_txp_rb_thr <= i_txp_cfg_thr;
				end else begin
					o_txp_rb_en  <= 1'b0;
					o_txp_rb_pol <= 1'b0;
					o_txp_rb_pin <= {PIN_W{1'b0}};
					o_txp_rb_thr <= {CNT_W{1'b0}};
				end
			end
			// Active from threshold until the software queue drains.
			if (!o_txp_rb_en)
				o_tx_pending_pin <= 1'b0;
			else if (i_tx_pending >= o_txp_rb_thr && i_tx_pending != {CNT_W{1'b0}})
				o_tx_pending_pin <= o_txp_rb_pol;
			else if (i_tx_pending == {CNT_W{1'b0}})
				o_tx_pending_pin <= ~o_txp_rb_pol;
		end
	end

	// Port idle timeout and recovery boot strap.
	always @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			idle_cnt_q       <= 32'h0;
			o_port_idle      <= 1'b0;
			strap_done_q     <= 1'b0;
			settle_q         <= 3'h0;
			rec_q            <= 1'b0;
			o_recovery_mode  <= 1'b0;
			o_usb_enable     <= 1'b0;
			o_positioning_en <= 1'b0;
			o_strap_spi      <= 1'b0;
		end else if (i_ce) begin
			if (byte_end) begin
				idle_cnt_q  <= 32'h0;
				o_port_idle <= 1'b0;
			end else if (idle_cnt_q >= IDLE_TIMEOUT_CYC - 1) begin
				if (!i_ext_timeout_en || i_undelivered >= `HPSI_EXT_LIMIT_BYTES)
					o_port_idle <= 1'b1;
			end else begin
				idle_cnt_q <= idle_cnt_q + 32'h1;
			end
			// The strap is taken once, after its synchroniser has settled.
			if (!strap_done_q) begin
				if (settle_q == `HPSI_STRAP_SETTLE) begin
					strap_done_q <= 1'b1;
					rec_q        <= ~pin_sync[4];
				end else begin
					settle_q <= settle_q + 3'h1;
				end
			end
			o_recovery_mode  <= rec_q;
			o_positioning_en <= strap_done_q & ~rec_q;
			o_usb_enable     <= strap_done_q & ~rec_q;
			o_strap_spi      <= spi_mode;
		end
	end

endmodule // hpsi_top

// ### tb_host_port_stream_interface.sv
// Purpose: Self-checking bench for the host port stream interface.
// Assumes: Idle timeout shortened to 200 cycles.
// Notes: Inputs change on the falling clock edge.
`timescale 1ns/1ns
module tb_host_port_stream_interface;
	reg         clk = 0, rst_b = 0, sel = 0, boot_b = 1, tx_valid = 0, cfg_wr = 0, cfg_en = 0;
	reg         cfg_pol = 0, pin_valid = 0, pin_used = 0, ext = 0, uart_tx = 1;
	reg  [7:0]  tx_data = 8'h00, r;
	reg  [3:0]  cfg_pin = 4'h0;
	reg  [12:0] pend = 13'h0000, thr = 13'h0000, undel = 13'h0000;
	integer     miscompares = 0, samples_checked = 0, cyc = 0, nrx = 0;
	wire [7:0]  rxd;
	wire [3:0]  rpin;
	wire [12:0] rthr;
	wire        miso, mosi, cs_n, sclk, txr, rxv, pact, ren, rpol, tpp, idle, rec, usb, pos, sspi;
	always #5 clk = ~clk;
	hpsi_host host (.i_miso(miso), .o_cs_n(cs_n), .o_sclk(sclk), .o_mosi(mosi));
	hpsi_top #(.IDLE_TIMEOUT_CYC(200)) dut (.i_core_clk(clk), .i_rst_b(rst_b), .i_ce(1'b1),
		.i_port_sel_pin(sel), .i_recovery_boot_pin_b(boot_b), .i_pin20(miso), .i_pin21(mosi),
		.i_pin18(cs_n), .i_pin19(sclk), .o_pin20(miso), .o_pin20_oe(), .o_pin18(),
		.o_pin18_oe(), .i_uart_tx(uart_tx), .o_uart_rx(), .i_i2c_sda(1'b1), .i_i2c_sda_oe(1'b0),
		.o_i2c_sda(), .o_i2c_scl(), .i_tx_data(tx_data), .i_tx_valid(tx_valid), .o_tx_ready(txr),
		.o_rx_data(rxd), .o_rx_valid(rxv), .o_parser_active(pact), .i_tx_pending(pend),
		.i_txp_cfg_wr(cfg_wr), .i_txp_cfg_en(cfg_en), .i_txp_cfg_pol(cfg_pol),
		.i_txp_cfg_pin(cfg_pin), .i_txp_cfg_thr(thr), .i_txp_pin_valid(pin_valid),
		.i_txp_pin_used(pin_used), .o_txp_rb_en(ren), .o_txp_rb_pol(rpol), .o_txp_rb_pin(rpin),
		.o_txp_rb_thr(rthr), .o_tx_pending_pin(tpp), .i_ext_timeout_en(ext),
		.i_undelivered(undel), .o_port_idle(idle), .o_recovery_mode(rec), .o_usb_enable(usb),
		.o_positioning_en(pos), .o_strap_spi(sspi));
	always @(posedge clk) if (rxv) nrx <= nrx + 1;
	always @(negedge clk) if (txr) tx_valid <= 1'b0;
	task chk(input [31:0] s, input [31:0] e);
		begin
			samples_checked = samples_checked + 1;
			if (s !== e) begin
				miscompares = miscompares + 1;
				$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
			end
		end
	endtask
	task tally_and_finish;
		begin
			$display("Checked %0d, mismatches %0d", samples_checked, miscompares);
			if (miscompares == 0 && samples_checked > 0) $display("Run complete: PASS");
			else $display("Run complete: FAIL");
			$finish;
		end
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			miscompares = miscompares + 1;
			tally_and_finish;
		end
	end
	task wt(input integer n);
		repeat (n) @(negedge clk);
	endtask
	task t_stream;
		begin
			@(negedge clk) tx_data = 8'hA5;
			tx_valid = 1'b1;
			host.xfer(8'h3C, r);
			chk(r, 8'hA5);
			chk(rxd, 8'h3C);
			chk(tx_valid, 1'b0);
			host.xfer(8'h96, r);
			chk(r, 8'hFF);
		end
	endtask
	task t_suspend;
		integer n0;
		begin
			n0 = nrx;
			repeat (50) host.xfer(8'hFF, r);
			chk(nrx - n0, 49);
			chk(pact, 1'b0);
			host.xfer(8'h42, r);
			chk({pact, rxd}, 9'h142);
		end
	endtask
	task t_txp;
		begin
			@(negedge clk) {cfg_en, cfg_pol, cfg_pin, thr, pin_valid, cfg_wr} = {6'h3D, 13'h00A, 2'h3};
			wt(1);
			cfg_wr = 1'b0;
			pend = 13'h0009;
			wt(3);
			chk({ren, rpol, rpin, rthr, tpp}, {6'h3D, 13'h00A, 1'b0});
			pend = 13'h000A;
			wt(3);
			chk(tpp, 1'b1);
			pend = 13'h0000;
			wt(3);
			chk(tpp, 1'b0);
			{pin_used, cfg_wr} = 2'h3;
			wt(1);
			cfg_wr = 1'b0;
			wt(2);
			chk({ren, rpol, rpin, rthr}, 0);
		end
	endtask
	task t_idle;
		begin
			wt(260);
			chk(idle, 1'b1);
			ext = 1'b1;
			host.xfer(8'h55, r);
			wt(260);
			chk(idle, 1'b0);
			undel = 13'h1000;
			wt(5);
			chk(idle, 1'b1);
		end
	endtask
	task t_strap;
		begin
			{sel, uart_tx} = 2'h2;
			wt(8);
			chk({sspi, miso}, 2'h0);
			uart_tx = 1'b1;
			wt(8);
			chk(miso, 1'b1);
			sel = 1'b0;
			wt(8);
			chk(sspi, 1'b1);
		end
	endtask
	task t_boot;
		begin
			{boot_b, rst_b} = 2'h0;
			wt(5);
			rst_b = 1'b1;
			wt(10);
			chk({rec, usb, pos}, 3'h4);
			host.xfer(8'h3C, r);
			chk(rxd, 8'h3C);
		end
	endtask
	initial begin
		wt(5);
		rst_b = 1'b1;
		wt(10);
		chk({ren, tpp, rec, usb, pos}, 5'h03);
		t_stream;
		t_suspend;
		t_txp;
		t_idle;
		t_strap;
		t_boot;
		tally_and_finish;
	end
endmodule // tb_host_port_stream_interface
